// *** rtl/regulator_pkg.sv ***
// constants, types and the setpoint decoder shared by the regulator control logic
// assumes one 200 MHz system clock; host transaction decoding lives outside this block
// Summary of operation
// - after reset every channel regulates to its built-in default setpoint until one is written.
// - a step-down channel takes its setpoint from the low bank while the select pin is low, else the high bank.
// - the setpoint is a 6-bit code, bits 5:3 a range column and 2:0 a step, 0.600 V to 3.900 V.
// - a step-down channel's on bit enables it at 1 and disables it at 0, independent of the others.
// - each channel has a 3-bit turn-on delay, 0 ms at code 0, 2 ms at code 1, doubling up to 128 ms.
// - a step-down channel's mode bit at 1 forces fixed-frequency operation, at 0 allows power saving.
// - a step-down channel's power-good bit reads 0 while its output is below the threshold, else 1.
// - with a channel unmasked and regulating, an output drop pulls the alert low until that power-good bit is read.
// - a linear channel's power-good bit reads 0 while its output is below its threshold.
// - a linear channel has one setpoint field with the same encoding and no bank selection.
// - a linear channel's on bit enables it at 1 and disables it at 0, independent of the others.
// - a linear channel's pull-down is on only while its discharge bit is 1 and it is disabled.
// - a linear channel's reduced-bias bit at 1 selects low-power bias, at 0 normal bias.
// - an enabled step-down channel follows a fixed soft-start ramp before it reports regulation.
package regulator_pkg;

  localparam int NUM_BUCK = 3;
  localparam int NUM_LDO = 4;
  localparam int NUM_CH = NUM_BUCK + NUM_LDO;
  localparam int CODE_W = 6;
  localparam int DELAY_W = 3;
  localparam int MV_W = 12;
  localparam int CNT_W = 32;

  localparam int CLK_PERIOD_NS = 5;
  localparam int DELAY_UNIT_MS = 2;
  localparam int SOFTSTART_US = 400;
  localparam int DELAY_UNIT_CYC = (DELAY_UNIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int SOFTSTART_CYC = (SOFTSTART_US * 1000) / CLK_PERIOD_NS;

  localparam logic [CODE_W-1:0] SETPOINT_RST = 6'h00;
  localparam logic [2:0] CHAN_INDEX_MAX = 3'h6;

  // decoded setpoint table, millivolts
  localparam logic [MV_W-1:0] COL_BASE_MV [8] = '{12'h258, 12'h320, 12'h3e8, 12'h4b0,
                                                 12'h640, 12'h7d0, 12'h960, 12'hc80};
  localparam logic [MV_W-1:0] COL_STEP_MV [8] = '{12'h019, 12'h019, 12'h019, 12'h032,
                                                 12'h032, 12'h032, 12'h064, 12'h064};

  typedef enum logic [1:0] {CH_OFF, CH_WAIT, CH_RAMP, CH_REG} ch_state_t;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic high_bank;
    logic [CODE_W-1:0] code;
  } sp_wr_t;

  typedef struct packed {
    logic drive_en;
    logic ramp_active;
    logic regulating;
    logic power_good;
    logic fault_pend;
  } ch_stat_t;

  function automatic logic [MV_W-1:0] code_to_mv(input logic [CODE_W-1:0] code);
    logic [MV_W-1:0] step;
    step = COL_STEP_MV[code[5:3]] * MV_W'(code[2:0]);
    return COL_BASE_MV[code[5:3]] + step;
  endfunction

endpackage

// *** rtl/channel_sequencer.sv ***
// one regulator channel: turn-on delay, soft-start, power-good and fault latch
// assumes the power-good comparator is an asynchronous pin and read pulses are on clk
module channel_sequencer
  import regulator_pkg::*;
#(
  parameter int DELAY_UNIT = DELAY_UNIT_CYC,
  parameter int RAMP_CYC = SOFTSTART_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic on,
  input wire logic [DELAY_W-1:0] delay_code,
  input wire logic unmask,
  input wire logic pg_pin,
  input wire logic ok_read,
  output ch_stat_t stat
);

  ch_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] target;
  logic [2:0] pg_sync_q;
  logic pg_q, pg_d;
  logic fault_q, fault_d;
  logic drop;

  // cycles of turn-on delay for the programmed code
  always_comb
  begin
    if (delay_code == '0)
      target = '0;
    else
      target = CNT_W'(DELAY_UNIT) << (delay_code - 3'h1);
  end

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (!on)
    begin
      state_d = CH_OFF;
      cnt_d = '0;
    end
    else
    begin
      unique case (state_q)
        CH_OFF:
        begin
          cnt_d = '0;
          state_d = (target == '0) ? CH_RAMP : CH_WAIT;
        end
        CH_WAIT:
        begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == target - 1'b1)
          begin
            cnt_d = '0;
            state_d = CH_RAMP;
          end
        end
        CH_RAMP:
        begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == CNT_W'(RAMP_CYC - 1))
          begin
            cnt_d = '0;
            state_d = CH_REG;
          end
        end
        CH_REG:
          cnt_d = '0;
      endcase
    end
  end

  // comparator level passes three flops; a change counts once stages two and three agree
  always_comb
  begin
    pg_d = pg_q;
    if (pg_sync_q[1] == pg_sync_q[2])
      pg_d = pg_sync_q[2];
    drop = pg_q && !pg_d;
    fault_d = fault_q;
    if (ok_read)
      fault_d = 1'b0;
    if (drop && unmask && state_q == CH_REG)
      fault_d = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= CH_OFF;
      cnt_q <= '0;
      pg_sync_q <= 3'h0;
      pg_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pg_sync_q <= {pg_sync_q[1:0], pg_pin};
      pg_q <= pg_d;
      fault_q <= fault_d;
    end
  end

  assign stat.drive_en = (state_q == CH_RAMP) || (state_q == CH_REG);
  assign stat.ramp_active = (state_q == CH_RAMP);
  assign stat.regulating = (state_q == CH_REG);
  assign stat.power_good = pg_q;
  assign stat.fault_pend = fault_q;

  chk_off_drops_drive: assert property (@(posedge clk) disable iff (!rst_n)
    !on |=> !stat.drive_en)
    else $error("channel still driven after its on bit cleared");

  chk_zero_delay_ramp: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == CH_OFF && on && delay_code == '0) |=> stat.ramp_active)
    else $error("zero delay did not start the ramp at once");

  chk_ramp_only_after: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == CH_WAIT && on && cnt_q < target - 1'b1) |=> !stat.drive_en)
    else $error("output driven before turn-on delay elapsed");

  chk_ramp_not_early: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(stat.ramp_active) && on && RAMP_CYC > 1 |=> stat.ramp_active && !stat.regulating)
    else $error("soft-start ended too early");

  chk_fault_latches: assert property (@(posedge clk) disable iff (!rst_n)
    (drop && unmask && state_q == CH_REG) |=> stat.fault_pend)
    else $error("unmasked power drop did not latch a fault");

  chk_fault_held: assert property (@(posedge clk) disable iff (!rst_n)
    (stat.fault_pend && !ok_read) |=> stat.fault_pend)
    else $error("fault cleared without a read");

  cov_delayed_start: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == CH_WAIT ##1 state_q == CH_RAMP);
  cov_fault_read: cover property (@(posedge clk) disable iff (!rst_n)
    stat.fault_pend ##1 !stat.fault_pend);

endmodule // channel_sequencer

// *** rtl/regulator_control_status.sv ***
// control and status for three step-down and four linear regulator channels
// assumes a transaction layer on clk delivers writes and read requests; scl,
// the bank-select pin and the comparators arrive asynchronously
module regulator_control_status
  import regulator_pkg::*;
#(
  parameter int DELAY_UNIT = DELAY_UNIT_CYC,
  parameter int RAMP_CYC = SOFTSTART_CYC,
  parameter logic [CODE_W-1:0] BUCK_DEFAULT_LOW = SETPOINT_RST,
  parameter logic [CODE_W-1:0] BUCK_DEFAULT_HIGH = SETPOINT_RST,
  parameter logic [CODE_W-1:0] LDO_DEFAULT = SETPOINT_RST
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic setpoint_bank_select_pin,
  input sp_wr_t sp_wr,
  input wire logic [NUM_CH-1:0] chan_on,
  input wire logic [NUM_CH*DELAY_W-1:0] turn_on_delay,
  input wire logic [NUM_BUCK-1:0] pwm_force,
  input wire logic [NUM_LDO-1:0] output_discharge_enable,
  input wire logic [NUM_LDO-1:0] reduced_bias_select,
  input wire logic [NUM_CH-1:0] fault_irq_unmask,
  input wire logic [NUM_CH-1:0] power_good_pin,
  input wire logic [NUM_CH-1:0] ok_read_req,
  output logic [NUM_CH-1:0] regulator_enable,
  output logic [NUM_CH-1:0] ramp_active,
  output logic [NUM_CH-1:0] regulating,
  output logic [NUM_CH-1:0] power_good,
  output logic [NUM_CH*CODE_W-1:0] output_setpoint_code,
  output logic [NUM_CH*MV_W-1:0] output_setpoint_mv,
  output logic [NUM_BUCK-1:0] fixed_pwm_mode,
  output logic [NUM_LDO-1:0] pulldown_on,
  output logic [NUM_LDO-1:0] low_bias_on,
  output logic host_alert_n
);

  logic [CODE_W-1:0] low_bank_q [NUM_BUCK];
  logic [CODE_W-1:0] low_bank_d [NUM_BUCK];
  logic [CODE_W-1:0] high_bank_q [NUM_BUCK];
  logic [CODE_W-1:0] high_bank_d [NUM_BUCK];
  logic [CODE_W-1:0] ldo_sp_q [NUM_LDO];
  logic [CODE_W-1:0] ldo_sp_d [NUM_LDO];
  logic [CODE_W-1:0] active_d [NUM_CH];
  logic [NUM_CH*CODE_W-1:0] code_q, code_d;
  logic [NUM_CH*MV_W-1:0] mv_q, mv_d;
  logic [2:0] sel_sync_q, scl_sync_q;
  logic sel_q, sel_d;
  logic scl_q, scl_d;
  logic scl_rise;
  logic [NUM_CH-1:0] ok_read;
  logic [NUM_CH-1:0] fault_pend;
  logic [NUM_BUCK-1:0] pwm_q, pwm_d;
  logic [NUM_LDO-1:0] pull_q, pull_d;
  logic [NUM_LDO-1:0] bias_q, bias_d;
  logic alert_n_q, alert_n_d;
  ch_stat_t stat [NUM_CH];

  // pin inputs pass three flops; the filtered level moves once stages two and three agree
  always_comb
  begin
    sel_d = sel_q;
    scl_d = scl_q;
    if (sel_sync_q[1] == sel_sync_q[2])
      sel_d = sel_sync_q[2];
    if (scl_sync_q[1] == scl_sync_q[2])
      scl_d = scl_sync_q[2];
    scl_rise = scl_d && !scl_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_sync_q <= 3'h0;
      scl_sync_q <= 3'h7;
      sel_q <= 1'b0;
      scl_q <= 1'b1;
    end
    else
    begin
      sel_sync_q <= {sel_sync_q[1:0], setpoint_bank_select_pin};
      scl_sync_q <= {scl_sync_q[1:0], scl};
      sel_q <= sel_d;
      scl_q <= scl_d;
    end
  end

  // a status read counts when the host clocks the byte out on a rising scl edge
  assign ok_read = scl_rise ? ok_read_req : '0;

  // setpoint storage: two banks per step-down channel, one field per linear channel
  always_comb
  begin
    for (int i = 0; i < NUM_BUCK; i++)
    begin
      low_bank_d[i] = low_bank_q[i];
      high_bank_d[i] = high_bank_q[i];
      if (sp_wr.valid && sp_wr.chan == 3'(i))
      begin
        if (sp_wr.high_bank)
          high_bank_d[i] = sp_wr.code;
        else
          low_bank_d[i] = sp_wr.code;
      end
    end
    for (int j = 0; j < NUM_LDO; j++)
    begin
      ldo_sp_d[j] = ldo_sp_q[j];
      if (sp_wr.valid && sp_wr.chan == 3'(j + NUM_BUCK) && sp_wr.chan <= CHAN_INDEX_MAX)
        ldo_sp_d[j] = sp_wr.code;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_BUCK; i++)
      begin
        low_bank_q[i] <= BUCK_DEFAULT_LOW;
        high_bank_q[i] <= BUCK_DEFAULT_HIGH;
      end
      for (int j = 0; j < NUM_LDO; j++)
        ldo_sp_q[j] <= LDO_DEFAULT;
    end
    else
    begin
      low_bank_q <= low_bank_d;
      high_bank_q <= high_bank_d;
      ldo_sp_q <= ldo_sp_d;
    end
  end

  // active setpoint and its decoded voltage, registered
  always_comb
  begin
    for (int i = 0; i < NUM_BUCK; i++)
      active_d[i] = sel_d ? high_bank_d[i] : low_bank_d[i];
    for (int j = 0; j < NUM_LDO; j++)
      active_d[j + NUM_BUCK] = ldo_sp_d[j];
    for (int k = 0; k < NUM_CH; k++)
    begin
      code_d[k*CODE_W +: CODE_W] = active_d[k];
      mv_d[k*MV_W +: MV_W] = code_to_mv(active_d[k]);
    end
  end

  // mode bits and the pull-down follow their control and the channel state
  always_comb
  begin
    pwm_d = pwm_force;
    bias_d = reduced_bias_select;
    for (int j = 0; j < NUM_LDO; j++)
      pull_d[j] = output_discharge_enable[j] && !chan_on[j + NUM_BUCK]
                  && !stat[j + NUM_BUCK].drive_en;
    alert_n_d = ~|fault_pend;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_q <= {{NUM_LDO{LDO_DEFAULT}}, {NUM_BUCK{BUCK_DEFAULT_LOW}}};
      mv_q <= '0;
      pwm_q <= '0;
      pull_q <= '0;
      bias_q <= '0;
      alert_n_q <= 1'b1;
    end
    else
    begin
      code_q <= code_d;
      mv_q <= mv_d;
      pwm_q <= pwm_d;
      pull_q <= pull_d;
      bias_q <= bias_d;
      alert_n_q <= alert_n_d;
    end
  end

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    channel_sequencer #(
      .DELAY_UNIT(DELAY_UNIT),
      .RAMP_CYC(c < NUM_BUCK ? RAMP_CYC : 1)
    ) u_seq (
      .clk(clk),
      .rst_n(rst_n),
      .on(chan_on[c]),
      .delay_code(turn_on_delay[c*DELAY_W +: DELAY_W]),
      .unmask(fault_irq_unmask[c]),
      .pg_pin(power_good_pin[c]),
      .ok_read(ok_read[c]),
      .stat(stat[c])
    );
    assign regulator_enable[c] = stat[c].drive_en;
    assign ramp_active[c] = stat[c].ramp_active;
    assign regulating[c] = stat[c].regulating;
    assign power_good[c] = stat[c].power_good;
    assign fault_pend[c] = stat[c].fault_pend;
  end

  assign output_setpoint_code = code_q;
  assign output_setpoint_mv = mv_q;
  assign fixed_pwm_mode = pwm_q;
  assign pulldown_on = pull_q;
  assign low_bias_on = bias_q;
  assign host_alert_n = alert_n_q;

  chk_bank_follows_pin: assert property (@(posedge clk) disable iff (!rst_n)
    output_setpoint_code[CODE_W-1:0] == $past(sel_d ? high_bank_d[0] : low_bank_d[0]))
    else $error("step-down setpoint not taken from the selected bank");

  chk_alert_from_fault: assert property (@(posedge clk) disable iff (!rst_n)
    (|fault_pend) |=> !host_alert_n)
    else $error("pending fault did not pull the alert low");

  chk_pulldown_when_off: assert property (@(posedge clk) disable iff (!rst_n)
    (chan_on[NUM_BUCK] || !output_discharge_enable[0]) |=> !pulldown_on[0])
    else $error("pull-down on while enabled or not allowed");

  chk_ldo_write_kept: assert property (@(posedge clk) disable iff (!rst_n)
    (sp_wr.valid && sp_wr.chan == 3'h3) |=> output_setpoint_code[3*CODE_W +: CODE_W]
      == $past(sp_wr.code))
    else $error("linear setpoint write not applied");

  chk_ldo_codes_held: assert property (@(posedge clk) disable iff (!rst_n)
    !sp_wr.valid |=> $stable(output_setpoint_code[NUM_CH*CODE_W-1:NUM_BUCK*CODE_W]))
    else $error("linear setpoint moved without a write");

  chk_bank_pin_filtered: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(sel_q) |-> $past(setpoint_bank_select_pin, 3) == sel_q
      && $past(setpoint_bank_select_pin, 4) == sel_q)
    else $error("bank select moved before two stages agreed");

  chk_alert_released: assert property (@(posedge clk) disable iff (!rst_n)
    !(|fault_pend) |=> host_alert_n)
    else $error("alert held low with no fault pending");

  chk_alert_needs_fault: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(host_alert_n) |-> $past(|fault_pend))
    else $error("alert fell without a pending fault");

  // per-channel guards
  for (genvar a = 0; a < NUM_CH; a++)
  begin : g_chk
    chk_mv_tracks_code: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> output_setpoint_mv[a*MV_W +: MV_W]
        == code_to_mv(output_setpoint_code[a*CODE_W +: CODE_W]))
      else $error("decoded millivolts do not match the active code");

    chk_masked_no_fault: assert property (@(posedge clk) disable iff (!rst_n)
      (!fault_irq_unmask[a] && !fault_pend[a]) |=> !fault_pend[a])
      else $error("masked channel latched a fault");

    chk_enable_needs_on: assert property (@(posedge clk) disable iff (!rst_n)
      !chan_on[a] |=> !regulator_enable[a])
      else $error("channel enabled while its on bit is clear");

    chk_pg_follows_filter: assert property (@(posedge clk) disable iff (!rst_n)
      $changed(power_good[a]) |-> $past(power_good_pin[a], 3) == power_good[a]
        && $past(power_good_pin[a], 4) == power_good[a])
      else $error("power-good status moved before two stages agreed");
  end

  // step-down guards
  for (genvar b = 0; b < NUM_BUCK; b++)
  begin : g_buck_chk
    chk_buck_bank_pick: assert property (@(posedge clk) disable iff (!rst_n)
      output_setpoint_code[b*CODE_W +: CODE_W]
        == $past(sel_d ? high_bank_d[b] : low_bank_d[b]))
      else $error("step-down setpoint not taken from the selected bank");

    chk_buck_write_shows: assert property (@(posedge clk) disable iff (!rst_n)
      (sp_wr.valid && sp_wr.chan == 3'(b) && sp_wr.high_bank == sel_d)
        |=> output_setpoint_code[b*CODE_W +: CODE_W] == $past(sp_wr.code))
      else $error("write to the selected bank not applied");

    chk_pwm_follows_bit: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> fixed_pwm_mode[b] == $past(pwm_force[b]))
      else $error("fixed-frequency mode does not follow its bit");
  end

  // linear guards
  for (genvar l = 0; l < NUM_LDO; l++)
  begin : g_ldo_chk
    chk_bias_follows_bit: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> low_bias_on[l] == $past(reduced_bias_select[l]))
      else $error("bias state does not follow its bit");

    chk_pulldown_when_allowed: assert property (@(posedge clk) disable iff (!rst_n)
      (output_discharge_enable[l] && !chan_on[l+NUM_BUCK] && !regulator_enable[l+NUM_BUCK])
        |=> pulldown_on[l])
      else $error("pull-down off although allowed and disabled");

    chk_ldo_quick_start: assert property (@(posedge clk) disable iff (!rst_n)
      (ramp_active[l+NUM_BUCK] && chan_on[l+NUM_BUCK]) |=> regulating[l+NUM_BUCK])
      else $error("linear channel did not reach regulation");
  end

  cov_bank_switch: cover property (@(posedge clk) disable iff (!rst_n) $changed(sel_q));
  cov_alert_raised: cover property (@(posedge clk) disable iff (!rst_n) $fell(host_alert_n));
  cov_pulldown_on: cover property (@(posedge clk) disable iff (!rst_n) $rose(pulldown_on[0]));

endmodule // regulator_control_status

// *** verification/host_model.sv ***
// host side model: reads a channel's power-good status as one scl frame
// assumes the block samples scl with its own clock; scl idles high between frames
module host_model
  import regulator_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] chan,
  output logic scl,
  output logic [NUM_CH-1:0] ok_read_req,
  output logic done
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    scl = 1'b1;
    ok_read_req = '0;
    done = 1'b0;
    forever
    begin
      @(posedge go);
      @(negedge clk);
      ok_read_req[chan] = 1'b1;
      // scl runs only inside the frame, 48 ns period
      repeat (3)
      begin
        #24 scl = 1'b0;
        #24 scl = 1'b1;
      end
      @(negedge clk);
      ok_read_req = '0;
      done = 1'b1;
      wait (go == 1'b0);
      done = 1'b0;
    end
  end
endmodule // host_model

// *** verification/regulator_control_status_tb_top.sv ***
// self-checking bench for the regulator control and status block
// assumes shortened delay unit and soft-start counts; host reads come from host_model
module regulator_control_status_tb_top
  import regulator_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DU = 20;
  localparam int RC = 10;
  logic clk, rst_n, scl, setpoint_bank_select_pin, host_alert_n, go, done;
  sp_wr_t sp_wr;
  logic [NUM_CH-1:0] chan_on, fault_irq_unmask, power_good_pin, ok_read_req;
  logic [NUM_CH-1:0] regulator_enable, ramp_active, regulating, power_good;
  logic [NUM_CH*DELAY_W-1:0] turn_on_delay;
  logic [NUM_BUCK-1:0] pwm_force, fixed_pwm_mode;
  logic [NUM_LDO-1:0] output_discharge_enable, reduced_bias_select, pulldown_on, low_bias_on;
  logic [NUM_CH*CODE_W-1:0] output_setpoint_code;
  logic [NUM_CH*MV_W-1:0] output_setpoint_mv;
  logic [2:0] rd_chan;
  int num_errors = 0;
  int n_checks = 0;

  regulator_control_status #(.DELAY_UNIT(DU), .RAMP_CYC(RC)) DUT (.clk, .rst_n, .scl,
    .setpoint_bank_select_pin, .sp_wr, .chan_on, .turn_on_delay, .pwm_force,
    .output_discharge_enable, .reduced_bias_select, .fault_irq_unmask, .power_good_pin,
    .ok_read_req, .regulator_enable, .ramp_active, .regulating, .power_good,
    .output_setpoint_code, .output_setpoint_mv, .fixed_pwm_mode, .pulldown_on,
    .low_bias_on, .host_alert_n);
  host_model host (.clk, .go, .chan(rd_chan), .scl, .ok_read_req, .done);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  function automatic int exp_mv(input logic [5:0] c);
    int base[8] = '{600, 800, 1000, 1200, 1600, 2000, 2400, 3200};
    int st[8] = '{25, 25, 25, 50, 50, 50, 100, 100};
    return base[c[5:3]] + st[c[5:3]] * c[2:0];
  endfunction

  function automatic logic [31:0] code_of(input int c);
    return 32'(output_setpoint_code[c*CODE_W +: CODE_W]);
  endfunction

  function automatic logic [31:0] mv_of(input int c);
    return 32'(output_setpoint_mv[c*MV_W +: MV_W]);
  endfunction

  task automatic wr(input logic [2:0] ch, input logic hb, input logic [5:0] code);
    @(negedge clk);
    sp_wr = '{1'b1, ch, hb, code};
    @(negedge clk);
    sp_wr.valid = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic rd(input logic [2:0] ch);
    int n;
    n = 0;
    rd_chan = ch;
    go = 1'b1;
    while (done !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk("read done", 32'h1, 32'(done));
    go = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_defaults;
    for (int c = 0; c < NUM_CH; c++)
    begin
      chk("default code", 32'h0, code_of(c));
      chk("default mv", 32'd600, mv_of(c));
    end
  endtask

  task automatic t_table;
    logic [5:0] codes[6] = '{6'h00, 6'h3f, 6'h1b, 6'h2e, 6'h07, 6'h38};
    foreach (codes[i])
    begin
      wr(3'h3, 1'b0, codes[i]);
      chk("ldo code", 32'(codes[i]), code_of(3));
      chk("ldo mv", 32'(exp_mv(codes[i])), mv_of(3));
    end
    wr(3'h4, 1'b1, 6'h11);
    chk("ldo bank ignored", 32'h11, code_of(4));
  endtask

  task automatic t_bank;
    wr(3'h0, 1'b0, 6'h08);
    wr(3'h0, 1'b1, 6'h10);
    chk("bank low", 32'h08, code_of(0));
    setpoint_bank_select_pin = 1'b1;
    repeat (10) @(negedge clk);
    chk("bank high", 32'h10, code_of(0));
    wr(3'h0, 1'b1, 6'h20);
    chk("retarget mv", 32'd1600, mv_of(0));
    wr(3'h7, 1'b1, 6'h3f);
    chk("chan7 ignored", 32'h0, code_of(6));
    setpoint_bank_select_pin = 1'b0;
    repeat (10) @(negedge clk);
    chk("bank back", 32'h08, code_of(0));
  endtask

  task automatic seq_one(input int c, input logic [2:0] dc);
    int n;
    int e;
    n = 0;
    e = (dc == 0) ? 1 : (DU << (dc - 1)) + 1;
    turn_on_delay[c*DELAY_W +: DELAY_W] = dc;
    chan_on[c] = 1'b1;
    while (ramp_active[c] !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
      if (n == e - 2)
        chk("enable in delay", 32'h0, 32'(regulator_enable[c]));
    end
    chk_rng("delay cycles", e - 1, e + 2, n);
    n = 0;
    while (regulating[c] !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk_rng("ramp cycles", RC - 1, RC + 1, n);
  endtask

  task automatic t_seq;
    seq_one(0, 3'h2);
    seq_one(1, 3'h7);
    seq_one(2, 3'h0);
    chan_on[0] = 1'b0;
    repeat (2) @(negedge clk);
    chk("buck enables", 32'h6, 32'(regulator_enable[2:0]));
  endtask

  task automatic t_fault;
    fault_irq_unmask = 7'h0a;
    repeat (8) @(negedge clk);
    chk("pg high", 32'h1, 32'(power_good[1]));
    power_good_pin[1] = 1'b0;
    repeat (8) @(negedge clk);
    chk("pg low", 32'h0, 32'(power_good[1]));
    chk("alert set", 32'h0, 32'(host_alert_n));
    power_good_pin[1] = 1'b1;
    repeat (30) @(negedge clk);
    chk("alert held", 32'h0, 32'(host_alert_n));
    rd(3'h1);
    chk("alert cleared", 32'h1, 32'(host_alert_n));
    power_good_pin[2] = 1'b0;
    repeat (10) @(negedge clk);
    chk("masked alert", 32'h1, 32'(host_alert_n));
  endtask

  task automatic t_modes;
    pwm_force = 3'b101;
    reduced_bias_select = 4'b0110;
    output_discharge_enable = 4'b1011;
    repeat (4) @(negedge clk);
    chk("pwm", 32'h5, 32'(fixed_pwm_mode));
    chk("bias", 32'h6, 32'(low_bias_on));
    chk("pulldown off", 32'hb, 32'(pulldown_on));
    chan_on[3] = 1'b1;
    repeat (4) @(negedge clk);
    chk("ldo on", 32'h1, 32'(regulating[6:3]));
    chk("pulldown on", 32'ha, 32'(pulldown_on));
    output_discharge_enable = 4'b0000;
    pwm_force = 3'b010;
    reduced_bias_select = 4'b1001;
    repeat (4) @(negedge clk);
    chk("pulldown none", 32'h0, 32'(pulldown_on));
    chk("pwm 2", 32'h2, 32'(fixed_pwm_mode));
    chk("bias 2", 32'h9, 32'(low_bias_on));
    power_good_pin[3] = 1'b0;
    repeat (8) @(negedge clk);
    chk("ldo pg", 32'h0, 32'(power_good[3]));
    chk("ldo alert", 32'h0, 32'(host_alert_n));
    power_good_pin[3] = 1'b1;
    rd(3'h3);
    chk("ldo alert clr", 32'h1, 32'(host_alert_n));
  endtask

  initial
  begin
    rst_n = 1'b0;
    setpoint_bank_select_pin = 1'b0;
    sp_wr = '0;
    chan_on = '0;
    turn_on_delay = '0;
    pwm_force = '0;
    output_discharge_enable = '0;
    reduced_bias_select = '0;
    fault_irq_unmask = '0;
    power_good_pin = '1;
    go = 1'b0;
    rd_chan = 3'h0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    t_defaults();
    t_table();
    t_bank();
    t_seq();
    t_fault();
    t_modes();
    final_report();
  end

  initial
  begin
    #50000;
    num_errors++;
    final_report();
  end
endmodule // regulator_control_status_tb_top
